// >>> logic/pcg_power_ctrl.sv
/*
 * Power control register logic: power reduction mode, scratch flags,
 * brownout interrupt enable, serial port options and peripheral gating.
 * Assumes a single-cycle special function register bus from the core,
 * a one-cycle timer 1 overflow pulse and a wake pulse from the interrupt
 * logic; all inputs are synchronous to sys_clk.
 */
// Overview of operation
// R01 - power_ctrl_reg bits 1:0 select the active power reduction mode.
// R02 - bit 2 is scratch_flag_a, read/write, with no hardware effect.
// R03 - bit 3 is scratch_flag_b, read/write, with no hardware effect.
// R04 - bit 4 set lets a brownout event raise an interrupt.
// R05 - bit 6 clear: serial control bit 7 reaches the uart mode bit.
// R06 - bit 6 set: serial control bit 7 reaches the framing error flag.
// R07 - bit 7 set with timer 1 as source: overflow rate passes undivided.
// R08 - bit 7 clear: timer 1 overflow rate is halved for the uart.
// R09 - periph_gate_reg bit 1 set stops the uart clock.
// R10 - either power-down mode stops the uart clock regardless.
// R11 - periph_gate_reg bit 3 set stops the two-wire bus clock.
// R12 - either power-down mode stops the two-wire bus clock regardless.
// R13 - periph_gate_reg bit 4 set stops the converter clock.
// R14 - software should also clear converter enables for full power-down.
// R15 - periph_gate_reg bit 5 set powers down the voltage comparators.
// R16 - software disables comparators before setting their power-down bit.
// R17 - periph_gate_reg bit 7 set stops the real-time clock.
// R18 - mode 11 is total power-down: brownout and comparators off too.
// R19 - all defined power_ctrl_reg bits reset to zero.
// R20 - reserved bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none

module pcg_power_ctrl (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       resetn,
   // special function register bus
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   output logic            sfr_hit,
   // serial control bit 7 redirection
   input  wire logic       uart_mode_bit_zero,
   input  wire logic       framing_error_flag,
   output logic            uart_mode_bit_we,
   output logic            framing_error_we,
   output logic            serial_bit7_wdata,
   output logic            serial_bit7_rdata,
   // baud source
   input  wire logic       timer1_overflow,
   input  wire logic       timer1_baud_source,
   output logic            uart_baud_tick,
   // brownout
   input  wire logic       brownout_event,
   output logic            brownout_irq,
   output logic            brownout_detector_en,
   // power state
   input  wire logic       wake_event,
   output logic            idle_req,
   output logic            power_down_req,
   output logic            total_power_down_req,
   // peripheral gating
   output logic            uart_clk_en,
   output logic            twowire_clk_en,
   output logic            converter_clk_en,
   output logic            rtc_clk_en,
   output logic            comparator_power_down
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic [7:0]            power_ctrl_q;
   logic [7:0]            power_ctrl_d;
   logic [7:0]            periph_gate_q;
   logic [7:0]            periph_gate_d;
   pcg_pkg::pcg_mode_type mode_q;
   pcg_pkg::pcg_mode_type mode_d;
   logic                  wr_power;
   logic                  wr_gate;
   logic                  wr_serial;
   logic                  rd_serial;
   logic                  fe_location;
   logic                  double_baud;
   logic                  baud_half_q;
   logic                  brownout_ok;
   logic [7:0]            rdata_d;

   pcg_gate_if gif ();

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   function automatic logic addr_is(input logic [7:0] a,
                                    input logic [7:0] target);
      addr_is = (a == target);
   endfunction

   assign wr_power  = sfr_wr && addr_is(sfr_addr, pcg_pkg::POWER_CTRL_ADDR);
   assign wr_gate   = sfr_wr && addr_is(sfr_addr, pcg_pkg::PERIPH_GATE_ADDR);
   assign wr_serial = sfr_wr && addr_is(sfr_addr, pcg_pkg::SERIAL_CTRL_ADDR);
   assign rd_serial = sfr_rd && addr_is(sfr_addr, pcg_pkg::SERIAL_CTRL_ADDR);

   // handshake output: high for the power control and gate addresses, not serial control
   assign sfr_hit = (sfr_wr || sfr_rd) &&
                    (addr_is(sfr_addr, pcg_pkg::POWER_CTRL_ADDR) ||
                     addr_is(sfr_addr, pcg_pkg::PERIPH_GATE_ADDR));

   // ------------------------------------------------------------
   // power control register
   // ------------------------------------------------------------
   // the mode field lives in mode_q so that wake can clear it;
   // the other bits sit in power_ctrl_q.
   always_comb begin
      power_ctrl_d = power_ctrl_q;
      if (wr_power) begin
         // scratch flags only store; only the readback below reads them
         power_ctrl_d = sfr_wdata & pcg_pkg::POWER_CTRL_MASK; // [R02] [R03] [R20]
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         power_ctrl_q <= pcg_pkg::POWER_CTRL_RESET; // [R19]
      end else begin
         power_ctrl_q <= power_ctrl_d;
      end
   end

   // ------------------------------------------------------------
   // power reduction mode
   // ------------------------------------------------------------
   // a write that lands together with a wake wins, so software that
   // re-enters a mode on the same cycle is not silently undone.
   always_comb begin
      mode_d = mode_q;
      if (wr_power) begin
         mode_d = pcg_pkg::pcg_mode_type'(
                  {sfr_wdata[pcg_pkg::POWER_SEL_HI_BIT],
                   sfr_wdata[pcg_pkg::POWER_SEL_LO_BIT]}); // [R01]
      end else if (wake_event) begin
         mode_d = pcg_pkg::mode_normal;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         mode_q <= pcg_pkg::mode_normal; // [R19]
      end else begin
         mode_q <= mode_d;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         idle_req             <= 1'b0;
         power_down_req       <= 1'b0;
         total_power_down_req <= 1'b0;
      end else begin
         idle_req             <= 1'b0;
         power_down_req       <= 1'b0;
         total_power_down_req <= 1'b0;
         unique case (mode_d) // [R01]
            pcg_pkg::mode_normal:     idle_req <= 1'b0;
            pcg_pkg::mode_idle:       idle_req <= 1'b1;
            pcg_pkg::mode_power_down: power_down_req <= 1'b1;
            pcg_pkg::mode_total_down: total_power_down_req <= 1'b1; // [R18]
         endcase
      end
   end

   // ------------------------------------------------------------
   // peripheral gate register
   // ------------------------------------------------------------
   always_comb begin
      periph_gate_d = periph_gate_q;
      if (wr_gate) begin
         // software is expected to disable comparators first [R16]
         periph_gate_d = sfr_wdata & pcg_pkg::PERIPH_GATE_MASK; // [R20]
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         periph_gate_q <= pcg_pkg::PERIPH_GATE_RESET;
      end else begin
         periph_gate_q <= periph_gate_d;
      end
   end

   // ------------------------------------------------------------
   // clock gate control
   // ------------------------------------------------------------
   assign gif.mode           = mode_q;
   assign gif.uart_off       = periph_gate_q[pcg_pkg::UART_OFF_BIT];       // [R09]
   assign gif.twowire_off    = periph_gate_q[pcg_pkg::TWOWIRE_OFF_BIT];    // [R11]
   assign gif.converter_off  = periph_gate_q[pcg_pkg::CONVERTER_OFF_BIT];  // [R13]
   assign gif.comparator_off = periph_gate_q[pcg_pkg::COMPARATOR_OFF_BIT]; // [R15]
   assign gif.rtc_off        = periph_gate_q[pcg_pkg::RTC_OFF_BIT];        // [R17]

   pcg_gate_ctrl u_gate (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .gif     (gif.gate)
   );

   assign uart_clk_en           = gif.uart_clk_en;
   assign twowire_clk_en        = gif.twowire_clk_en;
   assign converter_clk_en      = gif.converter_clk_en;
   assign rtc_clk_en            = gif.rtc_clk_en;
   assign comparator_power_down = gif.comparator_power_down;
   assign brownout_detector_en  = gif.brownout_enable;

   // ------------------------------------------------------------
   // serial control bit 7 redirection
   // ------------------------------------------------------------
   // the serial register itself lives in the uart; this block only
   // steers which flop bit 7 of it reaches.
   assign fe_location = power_ctrl_q[pcg_pkg::FE_LOCATION_BIT];

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         uart_mode_bit_we  <= 1'b0;
         framing_error_we  <= 1'b0;
         serial_bit7_wdata <= 1'b0;
      end else begin
         uart_mode_bit_we  <= wr_serial && !fe_location; // [R05]
         framing_error_we  <= wr_serial && fe_location;  // [R06]
         if (wr_serial) begin
            serial_bit7_wdata <= sfr_wdata[pcg_pkg::SERIAL_BIT7];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         serial_bit7_rdata <= 1'b0;
      end else if (rd_serial) begin
         serial_bit7_rdata <= fe_location ? framing_error_flag  // [R06]
                                          : uart_mode_bit_zero; // [R05]
      end
   end

   // ------------------------------------------------------------
   // uart baud source
   // ------------------------------------------------------------
   // halving keeps a phase flop; it only advances on overflows that
   // the uart actually uses as its baud source.
   assign double_baud = power_ctrl_q[pcg_pkg::DOUBLE_BAUD_BIT];

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         baud_half_q <= 1'b0;
      end else if (timer1_overflow && timer1_baud_source) begin
         baud_half_q <= !baud_half_q; // [R08]
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         uart_baud_tick <= 1'b0;
      end else begin
         uart_baud_tick <= timer1_overflow && timer1_baud_source &&
                           (double_baud || baud_half_q); // [R07] [R08]
      end
   end

   // ------------------------------------------------------------
   // brownout interrupt
   // ------------------------------------------------------------
   // in total power-down the detector is off, so no request may leak
   assign brownout_ok = (mode_q != pcg_pkg::mode_total_down); // [R18]

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         brownout_irq <= 1'b0;
      end else begin
         brownout_irq <= brownout_event && brownout_ok &&
                         power_ctrl_q[pcg_pkg::BROWNOUT_IRQ_BIT]; // [R04]
      end
   end

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   always_comb begin
      rdata_d = 8'h00;
      if (addr_is(sfr_addr, pcg_pkg::POWER_CTRL_ADDR)) begin
         rdata_d = power_ctrl_q & pcg_pkg::POWER_CTRL_MASK; // [R20]
         rdata_d[pcg_pkg::POWER_SEL_HI_BIT] = mode_q[1];    // [R01]
         rdata_d[pcg_pkg::POWER_SEL_LO_BIT] = mode_q[0];
      end else if (addr_is(sfr_addr, pcg_pkg::PERIPH_GATE_ADDR)) begin
         rdata_d = periph_gate_q & pcg_pkg::PERIPH_GATE_MASK; // [R20]
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd) begin
         sfr_rdata <= rdata_d;
      end
   end

endmodule

`default_nettype wire

// >>> logic/pcg_pkg.sv
/*
 * Shared constants and types for the power control and clock gating block.
 * Assumes an 8-bit special function register space on the core side.
 */
package pcg_pkg;

   // ---------------------------------------------------------------
   // register addresses in the special function register space
   // ---------------------------------------------------------------
   localparam logic [7:0] POWER_CTRL_ADDR  = 8'h87;
   localparam logic [7:0] PERIPH_GATE_ADDR = 8'hB5;
   localparam logic [7:0] SERIAL_CTRL_ADDR = 8'h98;

   // ---------------------------------------------------------------
   // power control register fields
   // ---------------------------------------------------------------
   localparam int POWER_SEL_LO_BIT   = 0;
   localparam int POWER_SEL_HI_BIT   = 1;
   localparam int SCRATCH_A_BIT      = 2;
   localparam int SCRATCH_B_BIT      = 3;
   localparam int BROWNOUT_IRQ_BIT   = 4;
   localparam int FE_LOCATION_BIT    = 6;
   localparam int DOUBLE_BAUD_BIT    = 7;
   localparam logic [7:0] POWER_CTRL_MASK  = 8'hDF;
   localparam logic [7:0] POWER_CTRL_RESET = 8'h00;

   // ---------------------------------------------------------------
   // peripheral gate register fields
   // ---------------------------------------------------------------
   localparam int UART_OFF_BIT       = 1;
   localparam int TWOWIRE_OFF_BIT    = 3;
   localparam int CONVERTER_OFF_BIT  = 4;
   localparam int COMPARATOR_OFF_BIT = 5;
   localparam int RTC_OFF_BIT        = 7;
   localparam logic [7:0] PERIPH_GATE_MASK  = 8'hBA;
   localparam logic [7:0] PERIPH_GATE_RESET = 8'h00;

   // ---------------------------------------------------------------
   // serial control register redirected bit
   // ---------------------------------------------------------------
   localparam int SERIAL_BIT7 = 7;

   // ---------------------------------------------------------------
   // power reduction modes
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      mode_normal     = 2'b00,
      mode_idle       = 2'b01,
      mode_power_down = 2'b10,
      mode_total_down = 2'b11
   } pcg_mode_type;

endpackage

// >>> logic/pcg_gate_if.sv
/*
 * Carrier between the register logic and the clock gate control.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface pcg_gate_if;
   pcg_pkg::pcg_mode_type mode;
   logic                  uart_off;
   logic                  twowire_off;
   logic                  converter_off;
   logic                  comparator_off;
   logic                  rtc_off;
   logic                  uart_clk_en;
   logic                  twowire_clk_en;
   logic                  converter_clk_en;
   logic                  rtc_clk_en;
   logic                  comparator_power_down;
   logic                  brownout_enable;

   modport regs (output mode, uart_off, twowire_off, converter_off,
                 comparator_off, rtc_off,
                 input  uart_clk_en, twowire_clk_en, converter_clk_en,
                 rtc_clk_en, comparator_power_down, brownout_enable);
   modport gate (input  mode, uart_off, twowire_off, converter_off,
                 comparator_off, rtc_off,
                 output uart_clk_en, twowire_clk_en, converter_clk_en,
                 rtc_clk_en, comparator_power_down, brownout_enable);
endinterface

`default_nettype wire

// >>> logic/pcg_gate_ctrl.sv
/*
 * Clock enable and analog power-down control for the peripherals.
 * Assumes downstream clock gate cells sample the enables glitch-free.
 */
`timescale 1ns/1ps
`default_nettype none

module pcg_gate_ctrl (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic resetn,
   // register side
   pcg_gate_if.gate  gif
);

   logic any_down;
   logic total_down;

   // ------------------------------------------------------------
   // mode decode
   // ------------------------------------------------------------
   assign any_down   = (gif.mode == pcg_pkg::mode_power_down) ||
                       (gif.mode == pcg_pkg::mode_total_down);
   assign total_down = (gif.mode == pcg_pkg::mode_total_down);

   // ------------------------------------------------------------
   // clock enables, flopped so a gate never sees a decode glitch
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         gif.uart_clk_en      <= 1'b1;
         gif.twowire_clk_en   <= 1'b1;
         gif.converter_clk_en <= 1'b1;
         gif.rtc_clk_en       <= 1'b1;
      end else begin
         gif.uart_clk_en      <= !(gif.uart_off || any_down);    // [R09] [R10]
         gif.twowire_clk_en   <= !(gif.twowire_off || any_down); // [R11] [R12]
         gif.converter_clk_en <= !gif.converter_off;             // [R13]
         gif.rtc_clk_en       <= !gif.rtc_off;                   // [R17]
      end
   end

   // ------------------------------------------------------------
   // analog power: comparators and brownout detector
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         gif.comparator_power_down <= 1'b0;
         gif.brownout_enable       <= 1'b1;
      end else begin
         gif.comparator_power_down <= gif.comparator_off || total_down; // [R15] [R18]
         gif.brownout_enable       <= !total_down;                      // [R18]
      end
   end

endmodule

`default_nettype wire

// >>> sim/pcg_power_ctrl_props.sv
/*
 * Port checker for the power control block.
 * Assumes one sys_clk domain and the async active-low resetn.
 */
`timescale 1ns/1ps
`default_nettype none

module pcg_power_ctrl_props (
   // clock and reset
   input wire logic       sys_clk,
   input wire logic       resetn,
   // register bus
   input wire logic [7:0] sfr_addr,
   input wire logic       sfr_wr,
   input wire logic       sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic       sfr_hit,
   // serial, baud, brownout, power state
   input wire logic       uart_mode_bit_we,
   input wire logic       framing_error_we,
   input wire logic       serial_bit7_wdata,
   input wire logic       timer1_overflow,
   input wire logic       timer1_baud_source,
   input wire logic       uart_baud_tick,
   input wire logic       brownout_event,
   input wire logic       brownout_irq,
   input wire logic       brownout_detector_en,
   input wire logic       wake_event,
   input wire logic       idle_req,
   input wire logic       power_down_req,
   input wire logic       total_power_down_req,
   input wire logic       uart_clk_en,
   input wire logic       twowire_clk_en,
   input wire logic       comparator_power_down
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   // a wake in the gap would clear the mode, so it is excluded
   property p_pwr_rd;
      sfr_wr && sfr_addr == 8'h87 && !wake_event ##1 !sfr_wr && !wake_event
         ##1 sfr_rd && sfr_addr == 8'h87 |=> sfr_rdata == ($past(sfr_wdata, 3) & 8'hDF);
   endproperty
   property p_gate_rd;
      sfr_wr && sfr_addr == 8'hB5 ##1 !sfr_wr ##1 sfr_rd && sfr_addr == 8'hB5
         |=> sfr_rdata == ($past(sfr_wdata, 3) & 8'hBA);
   endproperty
   property p_unmapped;
      sfr_rd && !(sfr_addr inside {8'h87, 8'hB5, 8'h98}) |=> sfr_rdata == 8'h00;
   endproperty
   property p_hit;
      sfr_hit == ((sfr_rd || sfr_wr) && (sfr_addr == 8'h87 || sfr_addr == 8'hB5));
   endproperty
   property p_serial_we;
      sfr_wr && sfr_addr == 8'h98
         |=> (uart_mode_bit_we ^ framing_error_we) && serial_bit7_wdata == $past(sfr_wdata[7]);
   endproperty
   property p_we_quiet;
      !(sfr_wr && sfr_addr == 8'h98) |=> !uart_mode_bit_we && !framing_error_we;
   endproperty
   property p_baud;
      uart_baud_tick |-> $past(timer1_overflow && timer1_baud_source);
   endproperty
   property p_brownout;
      brownout_irq |-> $past(brownout_event) && !total_power_down_req;
   endproperty
   property p_mode_onehot;
      $onehot0({idle_req, power_down_req, total_power_down_req});
   endproperty
   property p_pd_gate;
      power_down_req || total_power_down_req |=> !uart_clk_en && !twowire_clk_en;
   endproperty
   property p_total;
      total_power_down_req [*2] |-> !brownout_detector_en && comparator_power_down;
   endproperty

   // ---------------------------------------------------------------
   // assertions and covers
   // ---------------------------------------------------------------
   a_pwr_rd: assert property (p_pwr_rd) else $error("power ctrl readback wrong");
   a_gate_rd: assert property (p_gate_rd) else $error("gate readback wrong");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not 0");
   a_hit: assert property (p_hit) else $error("hit decode wrong");
   a_serial_we: assert property (p_serial_we) else $error("serial bit7 steer wrong");
   a_we_quiet: assert property (p_we_quiet) else $error("stray serial write pulse");
   a_baud: assert property (p_baud) else $error("baud tick without overflow");
   a_brownout: assert property (p_brownout) else $error("brownout irq without cause");
   a_mode_onehot: assert property (p_mode_onehot) else $error("several mode requests");
   a_pd_gate: assert property (p_pd_gate) else $error("clock runs in power-down");
   a_total: assert property (p_total) else $error("total power-down leaves analog on");
   c_total: cover property (total_power_down_req);
   c_fe_we: cover property (framing_error_we);
   c_irq: cover property (brownout_irq);
endmodule

// every checker port has a same-named port on the bound module
bind pcg_power_ctrl pcg_power_ctrl_props pcg_power_ctrl_props_i (.*);

`default_nettype wire

// >>> sim/pcg_power_ctrl_tb.sv
/*
 * Self-checking bench for the power control block.
 * Assumes the design files and the port checker are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module pcg_power_ctrl_tb;
   logic       sys_clk = 1'b0;
   logic       resetn, sfr_wr, sfr_rd, sfr_hit, mbit, fef, mwe, fwe, b7w, b7r;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v;
   logic       ovf, src, tick, bo, irq, bod, wake, idl, pd, tpd, uen, ten, cen, ren, cpd;
   int         miscompares = 0;
   int         tests_run = 0;

   always #5 sys_clk = ~sys_clk;

   pcg_power_ctrl pcg_power_ctrl_i (
      .sys_clk(sys_clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
      .uart_mode_bit_zero(mbit), .framing_error_flag(fef), .uart_mode_bit_we(mwe),
      .framing_error_we(fwe), .serial_bit7_wdata(b7w), .serial_bit7_rdata(b7r),
      .timer1_overflow(ovf), .timer1_baud_source(src), .uart_baud_tick(tick),
      .brownout_event(bo), .brownout_irq(irq), .brownout_detector_en(bod),
      .wake_event(wake), .idle_req(idl), .power_down_req(pd), .total_power_down_req(tpd),
      .uart_clk_en(uen), .twowire_clk_en(ten), .converter_clk_en(cen), .rtc_clk_en(ren),
      .comparator_power_down(cpd));

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic finish_test;
      $display("checks %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t %s: got %h expected %h", $time, msg, got, exp);
      end
   endtask

   task automatic check1(input logic got, input logic exp, input string msg);
      check({7'h00, got}, {7'h00, exp}, msg);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      sfr_wr <= 1'b1;
      sfr_addr <= a;
      sfr_wdata <= d;
      @(posedge sys_clk);
      sfr_wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      sfr_rd <= 1'b1;
      sfr_addr <= a;
      #1;
      check1(sfr_hit, a != 8'h55 && a != 8'h98, "hit decode");
      @(posedge sys_clk);
      sfr_rd <= 1'b0;
      #1;
      d = sfr_rdata;
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   // gate outputs packed in register bit order; idle value 9A
   function automatic logic [7:0] gates();
      return {ren, 1'b0, cpd, cen, ten, 1'b0, uen, 1'b0};
   endfunction

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      rd(8'h87, v);
      check(v, 8'h00, "power reset");
      rd(8'hB5, v);
      check(v, 8'h00, "gate reset");
      check(gates() | 8'(bod), 8'h9B, "outputs after reset");
   endtask

   task automatic t_power_rw;
      wr(8'h87, 8'hFF);
      rd(8'h87, v);
      check(v, 8'hDF, "reserved bit 5");
      wr(8'h87, 8'h0C);
      rd(8'h87, v);
      check(v, 8'h0C, "scratch flags");
      check(gates() | 8'(bod), 8'h9B, "scratch has no effect");
   endtask

   task automatic t_gate;
      int bits[5] = '{1, 3, 4, 5, 7};
      foreach (bits[i]) begin
         // converter and comparators are never enabled here, as software must keep them
         wr(8'hB5, 8'h01 << bits[i]);
         step(1);
         check(gates(), 8'h9A ^ (8'h01 << bits[i]), "gate bit");
      end
      wr(8'hB5, 8'hFF);
      rd(8'hB5, v);
      check(v, 8'hBA, "gate reserved bits");
      wr(8'hB5, 8'h00);
   endtask

   task automatic t_modes;
      for (int m = 0; m < 4; m++) begin
         wr(8'h87, 8'(m));
         check({5'h00, tpd, pd, idl}, (m == 0) ? 8'h00 : 8'h01 << (m - 1), "mode req");
         step(1);
         check({4'h0, uen, ten, bod, cpd}, {4'h0, m < 2, m < 2, m != 3, m == 3},
               "mode gating");
      end
      @(posedge sys_clk);
      wake <= 1'b1;
      @(posedge sys_clk);
      wake <= 1'b0;
      rd(8'h87, v);
      check(v, 8'h00, "wake clears mode");
   endtask

   task automatic t_serial;
      for (int s = 0; s < 2; s++) begin
         wr(8'h87, s ? 8'h40 : 8'h00);
         wr(8'h98, 8'h80);
         check({5'h00, mwe, fwe, b7w}, s ? 8'h03 : 8'h05, "serial bit7 steer");
         @(posedge sys_clk);
         fef <= 1'(s);
         mbit <= 1'(!s);
         rd(8'h98, v);
         check1(b7r, 1'b1, "serial bit7 read source");
      end
   endtask

   task automatic t_baud;
      int n;
      for (int s = 0; s < 2; s++) begin
         wr(8'h87, s ? 8'h00 : 8'h80);
         n = 0;
         repeat (4) begin
            @(posedge sys_clk);
            ovf <= 1'b1;
            @(posedge sys_clk);
            ovf <= 1'b0;
            #1;
            n += int'(tick === 1'b1);
         end
         check(8'(n), s ? 8'd2 : 8'd4, "baud ticks per 4 overflows");
      end
   endtask

   task automatic t_brownout;
      logic [7:0] vals[3] = '{8'h10, 8'h00, 8'h13};
      foreach (vals[i]) begin
         wr(8'h87, vals[i]);
         @(posedge sys_clk);
         bo <= 1'b1;
         @(posedge sys_clk);
         bo <= 1'b0;
         #1;
         check1(irq, i == 0, "brownout irq");
      end
      wr(8'h87, 8'h00);
   endtask

   task automatic t_unmapped;
      rd(8'h55, v);
      check(v, 8'h00, "unmapped read");
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      {resetn, sfr_wr, sfr_rd, mbit, fef, ovf, bo, wake} = '0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      src = 1'b1;
      repeat (3) @(posedge sys_clk);
      resetn <= 1'b1;
      t_reset();
      t_power_rw();
      t_gate();
      t_modes();
      t_serial();
      t_baud();
      t_brownout();
      t_unmapped();
      finish_test();
   end

   // hang guard: a stuck run counts as a mismatch
   initial begin
      #200000;
      miscompares++;
      finish_test();
   end
endmodule

`default_nettype wire
